//--- rtl/smsup_top.sv
// Supply monitor, operating mode and reset supervisor
`timescale 1ns/1ps
`include "smsup_defs.svh"

// Summary of operation
// - Battery undervoltage flag latched until acknowledged
// - I/O undervoltage flag set only when released
// - Power-release drop sets clear-on-read power-up flag
// - I/O undervoltage flag latched until acknowledged
// - Power up on battery plus input or idle
// - Sleep: outputs off, registers held default
// - Idle: channels off, no on-diagnostics, serial ok
// - Force-active holds active mode
// - Active needs idle, drive source, enabled channel
// - Active to idle when idle low and all requests gone
// - I/O undervoltage with idle high blocks idle to active
// - Input high with idle low enters limp
// - Limp mode: reads only, writes ignored
// - Limp: inputs drive channels two, three only
// - Limp: overload checks kept on two, three
// - Open-load-on checks only in active mode
// - Limp to sleep blocks writes, resets registers
// - Four causes reset read/write registers
// - Register reset leaves channels two, three on inputs
// - Register reset keeps diagnostics and supply flags
// - Internal failure or uv, inputs low, resets logic
// - Idle to active within one microsecond
// - Active to idle within 150 microseconds
module smsup_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic battery_present,
  input wire logic battery_uv_status,
  input wire logic io_supply_uv_status,
  input wire logic internal_supply_fail,
  input wire logic parallel_input_first,
  input wire logic parallel_input_second,
  input wire logic idle_pin,
  input wire logic force_active,
  input wire logic sw_reset,
  input wire logic reset_sense_en,
  input wire logic external_reset_pin_n,
  input wire logic status_read,
  input wire logic [7:0] serial_output_command,
  input wire logic [7:0] pwm_gen_active,
  input wire logic [7:0] channel_enable,
  input wire logic [7:0] first_input_mapping,
  input wire logic [7:0] second_input_mapping,
  input wire logic [7:0] open_load_on_check_enable,
  input wire logic [7:0] overload_detect,
  output logic [1:0] mode_status,
  output logic battery_uv_flag,
  output logic io_supply_uv_flag,
  output logic power_up_event_flag,
  output logic reg_write_allow,
  output logic reg_reset,
  output logic logic_reset,
  output logic [7:0] channel_on,
  output logic [7:0] open_load_check_run,
  output logic [7:0] overload_check_en,
  output logic [7:0] overload_overheat_diag
);
  // ==========================================================
  // Declarations
  localparam int IDLE2ACT_MAX = `SMSUP_IDLE2ACT_CYC;
  localparam logic [9:0] IDLE_FLT_LAST = 10'(`SMSUP_IDLE_FLT_CYC - 1);
  smsup_pkg::smsup_mode_type mode_q;
  smsup_pkg::smsup_mode_type mode_d;
  logic [1:0] mode_status_d;
  logic [9:0] flt_cnt_q;
  logic idle_f_q;
  logic por_released_q;
  logic any_in;
  logic drive_req;
  logic any_en;
  logic leave_active;
  logic [7:0] chan_d;
  logic [7:0] ol_d;
  logic [7:0] ovc_d;

  // Combined request terms
  assign any_in = parallel_input_first | parallel_input_second;
  assign drive_req = (|first_input_mapping) | (|second_input_mapping) |
                     (|serial_output_command) | (|pwm_gen_active);
  assign any_en = |channel_enable;
  assign leave_active = !idle_f_q && !any_in && !(|serial_output_command) &&
                        !(|pwm_gen_active);

  // ==========================================================
  // Idle pin deglitch: level accepted after a stable run
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flt_cnt_q <= 10'h000;
      idle_f_q <= 1'b0;
    end else if (idle_pin == idle_f_q) begin
      flt_cnt_q <= 10'h000;
    end else if (flt_cnt_q == IDLE_FLT_LAST) begin
      flt_cnt_q <= 10'h000;
      idle_f_q <= idle_pin;
    end else begin
      flt_cnt_q <= flt_cnt_q + 10'h001;
    end
  end

  // ==========================================================
  // Reset conditions
  // Full logic reset on internal failure or uv with inputs low
  assign logic_reset = internal_supply_fail || (io_supply_uv_status && !any_in);

  // Register reset causes, plus sleep holding defaults
  assign reg_reset = io_supply_uv_status || (!idle_f_q && !any_in) || sw_reset ||
                     (reset_sense_en && !external_reset_pin_n) ||
                     (mode_q == smsup_pkg::SMSUP_SLEEP);

  // Writes only in idle or active with registers not in reset
  assign reg_write_allow = ((mode_q == smsup_pkg::SMSUP_IDLE) ||
                            (mode_q == smsup_pkg::SMSUP_ACTIVE)) &&
                           !reg_reset;

  // Power-on-reset-released marker, low in the cycle after each logic-reset cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      por_released_q <= 1'b0;
    end else begin
      por_released_q <= !logic_reset;
    end
  end

  // ==========================================================
  // Mode state machine
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      smsup_pkg::SMSUP_SLEEP: begin
        if (battery_present && (any_in || idle_f_q)) begin
          mode_d = idle_f_q ? smsup_pkg::SMSUP_IDLE : smsup_pkg::SMSUP_LIMP;
        end
      end
      smsup_pkg::SMSUP_IDLE: begin
        if (!idle_f_q) begin
          mode_d = any_in ? smsup_pkg::SMSUP_LIMP : smsup_pkg::SMSUP_SLEEP;
        end else if (io_supply_uv_status || battery_uv_status) begin
          mode_d = smsup_pkg::SMSUP_IDLE;
        end else if (force_active || (drive_req && any_en)) begin
          mode_d = smsup_pkg::SMSUP_ACTIVE;
        end
      end
      smsup_pkg::SMSUP_ACTIVE: begin
        if (idle_f_q && io_supply_uv_status && !any_in) begin
          mode_d = smsup_pkg::SMSUP_IDLE;
        end else if (force_active) begin
          mode_d = smsup_pkg::SMSUP_ACTIVE;
        end else if (!idle_f_q && any_in) begin
          mode_d = smsup_pkg::SMSUP_LIMP;
        end else if (leave_active) begin
          mode_d = smsup_pkg::SMSUP_IDLE;
        end
      end
      smsup_pkg::SMSUP_LIMP: begin
        if (idle_f_q) begin
          mode_d = smsup_pkg::SMSUP_IDLE;
        end else if (!any_in) begin
          mode_d = smsup_pkg::SMSUP_SLEEP;
        end
      end
      default: begin
        mode_d = smsup_pkg::SMSUP_SLEEP;
      end
    endcase
    if (logic_reset) begin
      mode_d = smsup_pkg::SMSUP_SLEEP;
    end
  end

  // Mode status code of the next state
  always_comb begin
    case (mode_d)
      smsup_pkg::SMSUP_IDLE: mode_status_d = `SMSUP_MODE_IDLE;
      smsup_pkg::SMSUP_ACTIVE: mode_status_d = `SMSUP_MODE_ACTIVE;
      smsup_pkg::SMSUP_LIMP: mode_status_d = `SMSUP_MODE_LIMP;
      default: mode_status_d = `SMSUP_MODE_SLEEP;
    endcase
  end

  // Mode register and its status code
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= smsup_pkg::SMSUP_SLEEP;
      mode_status <= `SMSUP_MODE_SLEEP;
    end else begin
      mode_q <= mode_d;
      mode_status <= mode_status_d;
    end
  end

  // ==========================================================
  // Channel commands and diagnostic enables
  always_comb begin
    chan_d = `SMSUP_RST_CHAN;
    ol_d = 8'h00;
    ovc_d = 8'h00;
    case (mode_d)
      smsup_pkg::SMSUP_ACTIVE: begin
        if (reg_reset) begin
          // Mapping cleared: only the default input pair remains
          chan_d[`SMSUP_LIMP_CH_A] = parallel_input_first;
          chan_d[`SMSUP_LIMP_CH_B] = parallel_input_second;
        end else if (!battery_uv_status) begin
          chan_d = ((first_input_mapping & {8{parallel_input_first}}) |
                    (second_input_mapping & {8{parallel_input_second}}) |
                    serial_output_command | pwm_gen_active) & channel_enable;
        end
        ol_d = open_load_on_check_enable;
        ovc_d = 8'hff;
      end
      smsup_pkg::SMSUP_LIMP: begin
        chan_d[`SMSUP_LIMP_CH_A] = parallel_input_first;
        chan_d[`SMSUP_LIMP_CH_B] = parallel_input_second;
        ovc_d = `SMSUP_LIMP_MASK;
      end
      default: begin
        chan_d = `SMSUP_RST_CHAN;
      end
    endcase
  end

  // Registered channel and diagnostic enable outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      channel_on <= `SMSUP_RST_CHAN;
      open_load_check_run <= 8'h00;
      overload_check_en <= 8'h00;
    end else begin
      channel_on <= chan_d;
      open_load_check_run <= ol_d;
      overload_check_en <= ovc_d;
    end
  end

  // Overload diagnostics, untouched by register reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      overload_overheat_diag <= 8'h00;
    end else begin
      overload_overheat_diag <= (overload_detect & overload_check_en) |
                                (status_read ? 8'h00 : overload_overheat_diag);
    end
  end

  // ==========================================================
  // Latched supply flags; set wins over acknowledge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      battery_uv_flag <= 1'b0;
    end else if (battery_uv_status) begin
      battery_uv_flag <= 1'b1;
    end else if (status_read) begin
      battery_uv_flag <= 1'b0;
    end
  end

  // I/O undervoltage flag only while power is released
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      io_supply_uv_flag <= 1'b0;
    end else if (io_supply_uv_status && por_released_q) begin
      io_supply_uv_flag <= 1'b1;
    end else if (status_read && !io_supply_uv_status) begin
      io_supply_uv_flag <= 1'b0;
    end
  end

  // Power-up event flag, clear on read
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      power_up_event_flag <= `SMSUP_RST_POWER_UP_FLAG;
    end else if (!por_released_q || logic_reset) begin
      power_up_event_flag <= 1'b1;
    end else if (status_read) begin
      power_up_event_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  force_stays_a : assert property (@(posedge clock) disable iff (sys_rst)
    (mode_q == smsup_pkg::SMSUP_ACTIVE && force_active && !logic_reset &&
     !(idle_f_q && io_supply_uv_status && !any_in))
    |=> mode_q == smsup_pkg::SMSUP_ACTIVE)
    else $error("Force-active left active mode");
  limp_enter_a : assert property (@(posedge clock) disable iff (sys_rst)
    (mode_q == smsup_pkg::SMSUP_SLEEP && battery_present && any_in && !idle_f_q &&
     !logic_reset) |=> mode_status == `SMSUP_MODE_LIMP)
    else $error("Limp mode not entered");
  limp_write_a : assert property (@(posedge clock) disable iff (sys_rst)
    mode_q == smsup_pkg::SMSUP_LIMP |-> !reg_write_allow)
    else $error("Write allowed in limp mode");
  limp_chan_a : assert property (@(posedge clock) disable iff (sys_rst)
    (mode_q == smsup_pkg::SMSUP_LIMP && $past(mode_q) == smsup_pkg::SMSUP_LIMP) |->
    ((channel_on & ~`SMSUP_LIMP_MASK) == 8'h00 &&
     channel_on[`SMSUP_LIMP_CH_A] == $past(parallel_input_first)))
    else $error("Limp channel mapping wrong");
  idle_off_a : assert property (@(posedge clock) disable iff (sys_rst)
    (mode_q != smsup_pkg::SMSUP_ACTIVE && mode_q != smsup_pkg::SMSUP_LIMP) |->
    (channel_on == 8'h00 && open_load_check_run == 8'h00))
    else $error("Outputs or checks on outside active");
  bat_latch_a : assert property (@(posedge clock) disable iff (sys_rst)
    (battery_uv_flag && !status_read) |=> battery_uv_flag)
    else $error("Battery flag dropped without read");
  io_gate_a : assert property (@(posedge clock) disable iff (sys_rst)
    $rose(io_supply_uv_flag) |-> $past(por_released_q))
    else $error("I/O flag set while not released");
  por_flag_a : assert property (@(posedge clock) disable iff (sys_rst)
    logic_reset |=> power_up_event_flag && mode_q == smsup_pkg::SMSUP_SLEEP)
    else $error("Logic reset not traced");
  act_lat_a : assert property (@(posedge clock) disable iff (sys_rst)
    (mode_q == smsup_pkg::SMSUP_IDLE && idle_f_q && (force_active || (drive_req && any_en)) &&
     !io_supply_uv_status && !battery_uv_status && !logic_reset)
    |-> ##[1:IDLE2ACT_MAX] mode_status == `SMSUP_MODE_ACTIVE)
    else $error("Active mode not reached in time");
  reg_rst_a : assert property (@(posedge clock) disable iff (sys_rst)
    (sw_reset || (reset_sense_en && !external_reset_pin_n)) |->
    (reg_reset && !reg_write_allow))
    else $error("Register reset cause missed");
  leave_act_a : assert property (@(posedge clock) disable iff (sys_rst)
    (mode_q == smsup_pkg::SMSUP_ACTIVE && !force_active && leave_active && !logic_reset)
    |=> mode_status == `SMSUP_MODE_IDLE)
    else $error("Active mode not left for idle");
  limp_ol_a : assert property (@(posedge clock) disable iff (sys_rst)
    mode_q == smsup_pkg::SMSUP_LIMP |-> open_load_check_run == 8'h00)
    else $error("Open-load check run in limp mode");

  // Main scenarios
  cov_active_c : cover property (@(posedge clock) disable iff (sys_rst)
    mode_q == smsup_pkg::SMSUP_IDLE ##1 mode_q == smsup_pkg::SMSUP_ACTIVE);
  cov_back_c : cover property (@(posedge clock) disable iff (sys_rst)
    mode_q == smsup_pkg::SMSUP_ACTIVE ##1 mode_q == smsup_pkg::SMSUP_IDLE);
  cov_limp_c : cover property (@(posedge clock) disable iff (sys_rst)
    mode_q == smsup_pkg::SMSUP_LIMP ##1 mode_q == smsup_pkg::SMSUP_SLEEP);
  cov_regrst_c : cover property (@(posedge clock) disable iff (sys_rst)
    mode_q == smsup_pkg::SMSUP_ACTIVE && reg_reset);
endmodule : smsup_top

//--- rtl/smsup_defs.svh
// Constants for the supply and mode supervisor
`ifndef SMSUP_DEFS_SVH
`define SMSUP_DEFS_SVH
// ==========================================================
// Widths and channel positions
`define SMSUP_NUM_CH 8
`define SMSUP_LIMP_CH_A 2
`define SMSUP_LIMP_CH_B 3
`define SMSUP_LIMP_MASK 8'h0c
// ==========================================================
// Mode status codes
`define SMSUP_MODE_SLEEP 2'h0
`define SMSUP_MODE_LIMP 2'h1
`define SMSUP_MODE_IDLE 2'h2
`define SMSUP_MODE_ACTIVE 2'h3
// ==========================================================
// Reset values
`define SMSUP_RST_CHAN 8'h00
`define SMSUP_RST_POWER_UP_FLAG 1'b1
// ==========================================================
// Timing
`define SMSUP_CLK_PERIOD_NS 5
`define SMSUP_IDLE_FLT_NS 5000
`define SMSUP_IDLE_FLT_CYC ((`SMSUP_IDLE_FLT_NS + `SMSUP_CLK_PERIOD_NS - 1) / `SMSUP_CLK_PERIOD_NS)
`define SMSUP_IDLE2ACT_NS 1000
`define SMSUP_IDLE2ACT_CYC (`SMSUP_IDLE2ACT_NS / `SMSUP_CLK_PERIOD_NS)
`define SMSUP_ACT2IDLE_NS 150000
`define SMSUP_ACT2IDLE_CYC (`SMSUP_ACT2IDLE_NS / `SMSUP_CLK_PERIOD_NS)
`endif

//--- rtl/smsup_pkg.sv
// Types for the supply and mode supervisor
package smsup_pkg;
  // ==========================================================
  // Operating modes, one-hot
  typedef enum logic [3:0] {
    SMSUP_SLEEP = 4'b0001,
    SMSUP_IDLE = 4'b0010,
    SMSUP_ACTIVE = 4'b0100,
    SMSUP_LIMP = 4'b1000
  } smsup_mode_type;
endpackage : smsup_pkg

//--- testbench/smsup_host.sv
// Host controller model: mode pins and status acknowledge
`timescale 1ns/1ps
module smsup_host (
  input wire logic clock,
  output logic idle_pin,
  output logic parallel_input_first,
  output logic parallel_input_second,
  output logic status_read
);
  // ==========================================================
  // Pins start low, all changes at the falling edge
  initial begin
    idle_pin = 1'b0;
    parallel_input_first = 1'b0;
    parallel_input_second = 1'b0;
    status_read = 1'b0;
  end
  // Set idle pin and both parallel inputs
  task automatic pins(input logic idl, input logic in_a, input logic in_b);
    @(negedge clock);
    idle_pin = idl;
    parallel_input_first = in_a;
    parallel_input_second = in_b;
  endtask : pins
  // One-cycle status read, which acknowledges the latched flags
  task automatic ack();
    @(negedge clock);
    status_read = 1'b1;
    @(negedge clock);
    status_read = 1'b0;
  endtask : ack
endmodule : smsup_host

//--- testbench/smsup_top_test.sv
// Self-checking bench for the supply and mode supervisor
`timescale 1ns/1ps
module smsup_top_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic bat_ok = 1'b0, bat_uv = 1'b0, io_uv = 1'b0, int_fail = 1'b0;
  logic force_act = 1'b0, sw_rst = 1'b0, sense_en = 1'b0, ext_rst_n = 1'b1;
  logic [7:0] cmd = 8'h00, pwm = 8'h00, ena = 8'h00, ovl = 8'h00;
  logic [7:0] map_a = 8'h00, map_b = 8'h00, ol_en = 8'h5a;
  logic idl, in_a, in_b, rd;
  logic [1:0] mode_status;
  logic bat_flag, io_flag, pu_flag, wr_ok, rreg, rlog;
  logic [7:0] chan, olc, ovc, diag;
  int n_mismatch = 0;
  int samples_checked = 0;
  // ==========================================================
  // Clock, host model and design
  always #2.5 clock = ~clock;
  smsup_host i_host (.clock(clock), .idle_pin(idl), .parallel_input_first(in_a),
    .parallel_input_second(in_b), .status_read(rd));
  smsup_top i_dut (.clock(clock), .sys_rst(sys_rst), .battery_present(bat_ok),
    .battery_uv_status(bat_uv), .io_supply_uv_status(io_uv),
    .internal_supply_fail(int_fail), .parallel_input_first(in_a),
    .parallel_input_second(in_b), .idle_pin(idl), .force_active(force_act),
    .sw_reset(sw_rst), .reset_sense_en(sense_en), .external_reset_pin_n(ext_rst_n),
    .status_read(rd), .serial_output_command(cmd), .pwm_gen_active(pwm),
    .channel_enable(ena), .first_input_mapping(map_a), .second_input_mapping(map_b),
    .open_load_on_check_enable(ol_en), .overload_detect(ovl),
    .mode_status(mode_status), .battery_uv_flag(bat_flag), .io_supply_uv_flag(io_flag),
    .power_up_event_flag(pu_flag), .reg_write_allow(wr_ok), .reg_reset(rreg),
    .logic_reset(rlog), .channel_on(chan), .open_load_check_run(olc),
    .overload_check_en(ovc), .overload_overheat_diag(diag));
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // Bounded wait for a mode code
  task automatic wait_mode(input logic [1:0] code, input int bound);
    int n;
    n = 0;
    while (mode_status !== code && n < bound) begin
      @(negedge clock);
      n++;
    end
    chk({6'h00, mode_status}, {6'h00, code});
    if (mode_status !== code) give_verdict();
  endtask : wait_mode
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({6'h00, mode_status}, 8'h00);
    chk(chan, 8'h00);
    chk(rreg, 1'b1);
    chk(pu_flag, 1'b1);
    i_host.ack();
    chk(pu_flag, 1'b0);
  endtask : t_reset
  task automatic t_limp();
    bat_ok = 1'b1;
    i_host.pins(1'b0, 1'b1, 1'b0);
    wait_mode(2'h1, 20);
    cyc(1);
    chk(chan, 8'h04);
    chk(wr_ok, 1'b0);
    chk(ovc, 8'h0c);
    chk(olc, 8'h00);
    i_host.pins(1'b0, 1'b1, 1'b1);
    ovl = 8'h04;
    cyc(3);
    ovl = 8'h00;
    chk(chan, 8'h0c);
    chk(diag, 8'h04);
  endtask : t_limp
  task automatic t_flags();
    bat_uv = 1'b1;
    cyc(3);
    chk(bat_flag, 1'b1);
    i_host.ack();
    chk(bat_flag, 1'b1);
    bat_uv = 1'b0;
    cyc(3);
    chk(bat_flag, 1'b1);
    i_host.ack();
    chk(bat_flag, 1'b0);
    io_uv = 1'b1;
    ovl = 8'h04;
    cyc(3);
    ovl = 8'h00;
    chk(io_flag, 1'b1);
    chk(rreg, 1'b1);
    chk(rlog, 1'b0);
    io_uv = 1'b0;
    cyc(3);
    chk(io_flag, 1'b1);
    chk(diag, 8'h04);
    i_host.ack();
    chk(io_flag, 1'b0);
  endtask : t_flags
  task automatic t_regreset();
    bat_uv = 1'b1;
    cyc(2);
    bat_uv = 1'b0;
    sw_rst = 1'b1;
    cyc(2);
    chk(rreg, 1'b1);
    chk(chan, 8'h0c);
    chk(bat_flag, 1'b1);
    sw_rst = 1'b0;
    sense_en = 1'b1;
    ext_rst_n = 1'b0;
    cyc(1);
    chk(rreg, 1'b1);
    ext_rst_n = 1'b1;
    i_host.ack();
  endtask : t_regreset
  task automatic t_active();
    i_host.pins(1'b1, 1'b0, 1'b0);
    cyc(1);
    chk(rreg, 1'b1);
    chk(wr_ok, 1'b0);
    cyc(900);
    chk({6'h00, mode_status}, 8'h00);
    wait_mode(2'h2, 200);
    chk(chan, 8'h00);
    cmd = 8'h01;
    pwm = 8'h02;
    ena = 8'h03;
    wait_mode(2'h3, 200);
    cyc(2);
    chk(chan, 8'h03);
    chk(olc, 8'h5a);
    chk(wr_ok, 1'b1);
    map_a = 8'h10;
    map_b = 8'h20;
    ena = 8'h3f;
    i_host.pins(1'b1, 1'b0, 1'b1);
    cyc(2);
    chk(chan, 8'h23);
    sw_rst = 1'b1;
    cyc(2);
    chk(chan, 8'h08);
    chk(wr_ok, 1'b0);
    sw_rst = 1'b0;
    i_host.pins(1'b1, 1'b0, 1'b0);
    force_act = 1'b1;
    cmd = 8'h00;
    pwm = 8'h00;
    cyc(100);
    chk({6'h00, mode_status}, 8'h03);
    force_act = 1'b0;
    i_host.pins(1'b0, 1'b0, 1'b0);
    wait_mode(2'h2, 1100);
    chk(chan, 8'h00);
    chk(olc, 8'h00);
  endtask : t_active
  task automatic t_logic_reset();
    io_uv = 1'b1;
    cyc(3);
    chk(rlog, 1'b1);
    chk({6'h00, mode_status}, 8'h00);
    chk(pu_flag, 1'b1);
    io_uv = 1'b0;
    force_act = 1'b0;
    int_fail = 1'b1;
    cyc(1);
    chk(rlog, 1'b1);
    int_fail = 1'b0;
    cyc(3);
  endtask : t_logic_reset
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    cyc(2);
    t_reset();
    t_limp();
    t_flags();
    t_regreset();
    t_active();
    t_logic_reset();
    give_verdict();
  end
endmodule : smsup_top_test
